// file: design/synth_global_config_decode.sv
// decode of the programmed global parameters of a clock synthesizer
// assumes programmed values are static and the mode pin is synchronous
//
// Behaviour
// R1: divider code 00 divides by four, 01 by two, 10 by one; 11 reserved
// R2: configurer uses divide-by-four only for 32 to 56 MHz references
// R3: output_on_unlock 0 holds clock outputs low while pll is unlocked
// R4: output_on_unlock 1 keeps clock outputs enabled regardless of lock
// R5: three-bit function selects mode pin use; 100, 101, 110 do nothing
// R6: codes 000, 001, 010 disable main, aux, or both outputs
// R7: code 011 makes the pin the ratio shift enable
// R8: code 111 lets the pin force aux source to code 10
// R9: user ratio is output over reference times 2^20, 12.20 unsigned
// R10: four user ratios held static, chosen by the modal selection
// R11: external driver holds pin low to enable, high to disable
// R12: in shift mapping, pin high enables shift, low disables it
// R13: aux override applies only while the pin is high
// R14: configurer never programs reserved divider or function codes
module synth_global_config_decode #(
    parameter int RATIO_SETS = synth_cfg_pkg::RATIO_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] ref_divider_select,
    input wire logic output_on_unlock,
    input wire logic [2:0] mode_pin_function,
    input wire logic third_mode_pin,
    input wire logic pllLocked,
    input wire logic [1:0] aux_source_select,
    input wire logic [1:0] ratio_shift_select,
    input wire logic [1:0] modeSelect,
    input wire logic [synth_cfg_pkg::RATIO_WIDTH*RATIO_SETS-1:0] user_ratio,
    output synth_cfg_pkg::decode_out_t decodeOut,
    output logic [1:0] shiftSelect,
    output logic [synth_cfg_pkg::RATIO_WIDTH-1:0] activeRatio
);

    // ****************************************
    // parameter check
    // ****************************************
    if (RATIO_SETS != synth_cfg_pkg::RATIO_COUNT) begin : g_bad_sets
        $error("ratio set count must match the two mode select pins");
    end

    synth_cfg_pkg::decode_out_t next_decodeOut;
    synth_cfg_pkg::pin_func_t pinFunc;
    logic unlockGate;
    logic pinDisMain;
    logic pinDisAux;

    assign pinFunc = synth_cfg_pkg::pin_func_t'(mode_pin_function);

    // ****************************************
    // combinational decode
    // ****************************************
    always_comb begin
        next_decodeOut = synth_cfg_pkg::DECODE_RESET;
        // reserved code keeps divide-by-one but flags invalid
        case (ref_divider_select)
            synth_cfg_pkg::REF_DIV4: next_decodeOut.refDivide = 3'h4; // R1
            synth_cfg_pkg::REF_DIV2: next_decodeOut.refDivide = 3'h2; // R1
            synth_cfg_pkg::REF_DIV1: next_decodeOut.refDivide = 3'h1; // R1
            default: begin
                next_decodeOut.refDivide = 3'h1;
                next_decodeOut.refDivValid = 1'b0;
            end
        endcase
        // outputs gated low while unlocked unless told otherwise
        unlockGate = output_on_unlock | pllLocked; // R3 R4
        pinDisMain = 1'b0;
        pinDisAux = 1'b0;
        next_decodeOut.auxSource = aux_source_select;
        case (pinFunc)
            synth_cfg_pkg::PIN_DIS_MAIN: pinDisMain = third_mode_pin; // R6
            synth_cfg_pkg::PIN_DIS_AUX: pinDisAux = third_mode_pin; // R6
            synth_cfg_pkg::PIN_DIS_BOTH: begin
                pinDisMain = third_mode_pin; // R6
                pinDisAux = third_mode_pin; // R6
            end
            synth_cfg_pkg::PIN_SHIFT_EN:
                next_decodeOut.shiftEnable = third_mode_pin; // R7 R12
            synth_cfg_pkg::PIN_AUX_FORCE: begin
                if (third_mode_pin) begin
                    next_decodeOut.auxSource = synth_cfg_pkg::AUX_SRC_PLL;
                end // R8 R13
            end
            default: ; // R5
        endcase
        next_decodeOut.mainEnable = unlockGate & ~pinDisMain;
        next_decodeOut.auxEnable = unlockGate & ~pinDisAux;
    end

    // ****************************************
    // registered control outputs
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            decodeOut <= synth_cfg_pkg::DECODE_RESET;
        end else begin
            decodeOut <= next_decodeOut;
        end
    end

    // shift selection only meaningful while shift is enabled
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shiftSelect <= 2'h0;
        end else begin
            shiftSelect <= ratio_shift_select;
        end
    end

    // ratios are static storage; selection by mode pins only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            activeRatio <= '0;
        end else begin
            activeRatio <= user_ratio[modeSelect*synth_cfg_pkg::RATIO_WIDTH
                +: synth_cfg_pkg::RATIO_WIDTH]; // R10
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_div_four: assert property ( // R1
        ref_divider_select == synth_cfg_pkg::REF_DIV4
        |=> decodeOut.refDivide == 3'h4)
        else $error("divide code 00 not decoded as four");
    chk_div_one: assert property ( // R1
        ref_divider_select == synth_cfg_pkg::REF_DIV1
        |=> decodeOut.refDivide == 3'h1 && decodeOut.refDivValid)
        else $error("divide code 10 not decoded as one");
    chk_unlock_low: assert property ( // R3
        !output_on_unlock && !pllLocked
        |=> !decodeOut.mainEnable && !decodeOut.auxEnable)
        else $error("outputs enabled while unlocked");
    chk_unlock_keep: assert property ( // R4
        output_on_unlock && !pllLocked && mode_pin_function == 3'h3
        |=> decodeOut.mainEnable && decodeOut.auxEnable)
        else $error("outputs gated though always enabled");
    chk_reserved_idle: assert property ( // R5
        mode_pin_function inside {3'h4, 3'h5, 3'h6}
        |=> !decodeOut.shiftEnable
        && decodeOut.auxSource == $past(aux_source_select))
        else $error("reserved pin code had an effect");
    chk_disable_both: assert property ( // R6
        mode_pin_function == 3'h2 && third_mode_pin
        |=> !decodeOut.mainEnable && !decodeOut.auxEnable)
        else $error("both outputs not disabled");
    chk_disable_aux: assert property ( // R6
        mode_pin_function == 3'h1 && third_mode_pin && pllLocked
        |=> decodeOut.mainEnable && !decodeOut.auxEnable)
        else $error("aux disable mapping wrong");
    chk_shift_enable: assert property ( // R7
        mode_pin_function == 3'h3
        |=> decodeOut.shiftEnable == $past(third_mode_pin))
        else $error("shift enable does not follow pin");
    chk_aux_force: assert property ( // R8
        mode_pin_function == 3'h7 && third_mode_pin
        |=> decodeOut.auxSource == 2'h2)
        else $error("aux source not forced");
    chk_aux_follow: assert property ( // R13
        mode_pin_function == 3'h7 && !third_mode_pin
        |=> decodeOut.auxSource == $past(aux_source_select))
        else $error("aux source overridden while pin low");
    chk_ratio_pick: assert property ( // R10
        modeSelect == 2'h3 |=> activeRatio == $past(user_ratio[127:96]))
        else $error("wrong ratio selected");
    chk_div_two: assert property ( // R1
        ref_divider_select == synth_cfg_pkg::REF_DIV2
        |=> decodeOut.refDivide == 3'h2 && decodeOut.refDivValid)
        else $error("divide code 01 not decoded as two");
    chk_div_reserved: assert property ( // R1
        ref_divider_select == synth_cfg_pkg::REF_DIV_RSVD
        |=> decodeOut.refDivide == 3'h1 && !decodeOut.refDivValid)
        else $error("reserved divide code not flagged");
    chk_locked_on: assert property ( // R3
        pllLocked && mode_pin_function == 3'h3
        |=> decodeOut.mainEnable && decodeOut.auxEnable)
        else $error("outputs gated while locked");
    chk_unlock_aux: assert property ( // R4
        output_on_unlock && !pllLocked && mode_pin_function == 3'h7
        |=> decodeOut.mainEnable && decodeOut.auxEnable)
        else $error("outputs gated in override mapping");
    chk_disable_main: assert property ( // R6
        mode_pin_function == 3'h0 && third_mode_pin && pllLocked
        |=> !decodeOut.mainEnable && decodeOut.auxEnable)
        else $error("main disable mapping wrong");
    chk_pin_low_on: assert property ( // R6
        mode_pin_function inside {3'h0, 3'h1, 3'h2} && !third_mode_pin
        && pllLocked |=> decodeOut.mainEnable && decodeOut.auxEnable)
        else $error("output disabled while pin low");
    chk_shift_other: assert property ( // R7
        mode_pin_function != 3'h3 |=> !decodeOut.shiftEnable)
        else $error("shift enabled outside shift mapping");
    chk_shift_pass: assert property ( // R7
        1'b1 |=> shiftSelect == $past(ratio_shift_select))
        else $error("shift selection not passed on");
    chk_aux_other: assert property ( // R8
        mode_pin_function != 3'h7
        |=> decodeOut.auxSource == $past(aux_source_select))
        else $error("aux source changed outside override");

    // ****************************************
    // per-set ratio checks
    // ****************************************
    // one check per stored set, so a wrong slice in any set is caught
    for (genvar s = 0; s < RATIO_SETS; s++) begin : g_ratio_chk
        chk_ratio_set: assert property ( // R10
            @(posedge sys_clk) disable iff (!rst_n)
            modeSelect == 2'(s) |=> activeRatio == $past(
            user_ratio[s*synth_cfg_pkg::RATIO_WIDTH
            +: synth_cfg_pkg::RATIO_WIDTH]))
            else $error("stored ratio set not selected");
    end

    cov_unlock_hold: cover property (!pllLocked && !output_on_unlock);
    cov_shift_on: cover property (decodeOut.shiftEnable);
    cov_aux_forced: cover property (
        mode_pin_function == 3'b111 && third_mode_pin);
    cov_reserved_div: cover property (!decodeOut.refDivValid);
    cov_pin_disable: cover property (
        pllLocked && mode_pin_function == 3'h2 && third_mode_pin);

endmodule // synth_global_config_decode

// file: shared/synth_cfg_pkg.sv
// package of encodings and field layouts for the global config decode
// assumes a single synchronous clock domain and static programmed values
package synth_cfg_pkg;

    // ****************************************
    // reference divider codes
    // ****************************************
    localparam logic [1:0] REF_DIV4 = 2'h0;
    localparam logic [1:0] REF_DIV2 = 2'h1;
    localparam logic [1:0] REF_DIV1 = 2'h2;
    localparam logic [1:0] REF_DIV_RSVD = 2'h3;

    // ****************************************
    // mode pin function codes
    // ****************************************
    typedef enum logic [2:0] {
        PIN_DIS_MAIN = 3'h0,
        PIN_DIS_AUX = 3'h1,
        PIN_DIS_BOTH = 3'h2,
        PIN_SHIFT_EN = 3'h3,
        PIN_RSVD4 = 3'h4,
        PIN_RSVD5 = 3'h5,
        PIN_RSVD6 = 3'h6,
        PIN_AUX_FORCE = 3'h7
    } pin_func_t;

    // ****************************************
    // aux source codes and ratio layout
    // ****************************************
    localparam logic [1:0] AUX_SRC_PLL = 2'h2;
    localparam int RATIO_INT_BITS = 12;
    localparam int RATIO_FRAC_BITS = 20;
    localparam int RATIO_WIDTH = RATIO_INT_BITS + RATIO_FRAC_BITS;
    localparam int RATIO_COUNT = 4;

    // ****************************************
    // grouped decode outputs
    // ****************************************
    typedef struct packed {
        logic [2:0] refDivide;
        logic refDivValid;
        logic mainEnable;
        logic auxEnable;
        logic shiftEnable;
        logic [1:0] auxSource;
    } decode_out_t;

    localparam decode_out_t DECODE_RESET = '{
        refDivide: 3'h4, refDivValid: 1'b1, mainEnable: 1'b0,
        auxEnable: 1'b0, shiftEnable: 1'b0, auxSource: 2'h0};

endpackage

// file: sim/mode_pin_driver.sv
// board-side driver of the third mode pin
// assumes the bench asks for disable with wantOff, no other load on the pin
module mode_pin_driver (
    input wire logic wantOff,
    output logic third_mode_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // pin drive
    // ****************************************
    // push-pull driver, never released, so the level is always defined
    // low keeps the mapped outputs on, high turns them off
    assign third_mode_pin = wantOff;
endmodule // mode_pin_driver

// file: sim/tb_synth_global_config_decode.sv
// self-checking bench for the global config decode
// assumes one 100 MHz clock and latency of one edge on every output
module tb_synth_global_config_decode;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus, model and checks
    // ****************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] ref_divider_select = 2'h0;
    logic output_on_unlock = 1'b0;
    logic [2:0] mode_pin_function = 3'h0;
    logic wantOff = 1'b0;
    logic third_mode_pin;
    logic pllLocked = 1'b0;
    logic [1:0] aux_source_select = 2'h0;
    logic [1:0] ratio_shift_select = 2'h0;
    logic [1:0] modeSelect = 2'h0;
    logic [127:0] user_ratio = 128'h0;
    synth_cfg_pkg::decode_out_t decodeOut;
    logic [1:0] shiftSelect;
    logic [31:0] activeRatio;
    logic [42:0] expVal;
    logic [42:0] rstVal;
    int numErrors = 0;
    int compares = 0;
    int seed = 32'hd233;

    synth_global_config_decode #(.RATIO_SETS(4)) i_synth_global_config_decode (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .ref_divider_select(ref_divider_select),
        .output_on_unlock(output_on_unlock),
        .mode_pin_function(mode_pin_function),
        .third_mode_pin(third_mode_pin), .pllLocked(pllLocked),
        .aux_source_select(aux_source_select),
        .ratio_shift_select(ratio_shift_select), .modeSelect(modeSelect),
        .user_ratio(user_ratio), .decodeOut(decodeOut),
        .shiftSelect(shiftSelect), .activeRatio(activeRatio));

    mode_pin_driver i_mode_pin_driver (
        .wantOff(wantOff), .third_mode_pin(third_mode_pin));

    function automatic logic [42:0] predict();
        int dv;
        bit on;
        bit pin;
        on = pllLocked | output_on_unlock;
        pin = third_mode_pin;
        dv = (ref_divider_select == 2'h3) ? 1 : 4 >> ref_divider_select;
        return {dv[2:0], ref_divider_select != 2'h3,
            on && !(pin && mode_pin_function inside {3'h0, 3'h2}),
            on && !(pin && mode_pin_function inside {3'h1, 3'h2}),
            mode_pin_function == 3'h3 && pin,
            (mode_pin_function == 3'h7 && pin) ?
                2'h2 : aux_source_select,
            ratio_shift_select, user_ratio[modeSelect*32 +: 32]};
    endfunction

    task automatic check();
        compares++;
        if ({decodeOut, shiftSelect, activeRatio} !== expVal) begin
            numErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time,
                {decodeOut, shiftSelect, activeRatio}, expVal);
        end
    endtask

    // one cycle: judge the last inputs, then apply a fresh random set
    task automatic step(input int fn);
        int r;
        @(negedge sys_clk);
        check();
        r = $random(seed);
        mode_pin_function = fn[2:0];
        {ref_divider_select, output_on_unlock, pllLocked, wantOff,
            aux_source_select, ratio_shift_select, modeSelect} = r[10:0];
        user_ratio = {$random(seed), $random(seed),
            $random(seed), $random(seed)};
        if (r[11]) user_ratio[31:0] = 32'h0013a92a;
        #1 expVal = predict();
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        rstVal = {synth_cfg_pkg::DECODE_RESET, 34'h0};
        expVal = rstVal;
        repeat (3) @(negedge sys_clk);
        check();
        rst_n = 1'b1;
        expVal = predict();
        // every pin function, reserved ones included, many random inputs
        for (int f = 0; f < 8; f++) begin
            for (int k = 0; k < 24; k++) step(f);
        end
        $display("test code sweep done");
        @(negedge sys_clk);
        check();
        rst_n = 1'b0;
        expVal = rstVal;
        @(negedge sys_clk);
        check();
        rst_n = 1'b1;
        expVal = predict();
        for (int k = 0; k < 16; k++) step(3'h7);
        @(negedge sys_clk);
        check();
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule // tb_synth_global_config_decode
